// >>> swl_pkg.sv
`default_nettype none
package swl_pkg;
    // Clock periods, ns
    localparam int unsigned SYS_CLK_NS  = 20;
    localparam int unsigned LINK_CLK_NS = 160;
    // Link clock divider, system cycles per link tick
    localparam logic [2:0] DIV_LAST = 3'(LINK_CLK_NS / SYS_CLK_NS - 1);
    localparam logic [2:0] DIV_HALF = 3'(LINK_CLK_NS / SYS_CLK_NS / 2);
    // Bit cell, in link ticks
    localparam logic [3:0] BIT_LAST    = 4'hf;
    localparam logic [3:0] HIGH_ZERO   = 4'h8;
    localparam logic [3:0] HIGH_ONE    = 4'hc;
    localparam logic [3:0] SAMPLE_TICK = 4'h5;
    localparam logic [3:0] SLV_DRIVE   = 4'h4;
    localparam logic [3:0] DECODE_THR  = 4'ha;
    // Framing
    localparam int unsigned BYTE_W       = 8;
    localparam logic [3:0]  MST_FRAME    = 4'h9;
    localparam logic [3:0]  SLV_FRAME    = 4'hc;
    localparam logic [2:0]  WAKE_SEQ     = 3'h4;
    localparam logic [2:0]  LAST_DATA    = 3'h7;
    localparam logic        IDLE_BIT     = 1'h0;
    localparam logic        START_BIT    = 1'h1;

    typedef enum logic [1:0] {RX_IDLE, RX_WOKE, RX_DATA} swl_mrx_t;
    typedef enum logic {SRX_IDLE, SRX_DATA} swl_srx_t;
endpackage : swl_pkg
`default_nettype wire

// >>> swl_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface swl_link_if;
    logic link_clk;
    logic master_voltage_signal;
    logic slave_current_signal;

    modport master (
        output link_clk,
        output master_voltage_signal,
        input  slave_current_signal
    );
    modport slave (
        input  link_clk,
        input  master_voltage_signal,
        output slave_current_signal
    );
endinterface : swl_link_if
`default_nettype wire

// >>> swl_sync.sv
`timescale 1ns/1ns
`default_nettype none
module swl_sync (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic ce_in,
    // Level
    input  wire logic d_in,
    output logic      q_out
);
    logic meta_ff;
    logic hold_ff;
    logic nxt_meta;
    logic nxt_hold;

    always_comb
    begin
        nxt_meta = meta_ff;
        nxt_hold = hold_ff;
        if (ce_in)
        begin
            nxt_meta = d_in;
            nxt_hold = meta_ff;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_ff <= 1'h0;
            hold_ff <= 1'h0;
        end
        else
        begin
            meta_ff <= nxt_meta;
            hold_ff <= nxt_hold;
        end
    end

    assign q_out = hold_ff;
endmodule : swl_sync
`default_nettype wire

// >>> swl_slave.sv
`timescale 1ns/1ns
`default_nettype none
module swl_slave (
    // Reset and enable, link clock domain
    input  wire logic                     RST_N_IN,
    input  wire logic                     CE_IN,
    // Transmit byte
    input  wire logic [swl_pkg::BYTE_W-1:0] TX_DATA_IN,
    input  wire logic                     TX_VALID_IN,
    output logic                          TX_READY_OUT,
    // Receive byte
    output logic [swl_pkg::BYTE_W-1:0]    RX_DATA_OUT,
    output logic                          RX_VALID_OUT,
    // Link
    swl_link_if.slave                     LINK
);
    logic                   mvs_s;
    logic                   mvs_d_ff;
    logic [3:0]             hi_cnt_ff;
    logic                   scs_ff;
    logic [11:0]            tx_sr_ff;
    logic [3:0]             tx_cnt_ff;
    swl_pkg::swl_srx_t      rx_st_ff;
    logic [7:0]             rx_sr_ff;
    logic [2:0]             rx_cnt_ff;
    logic [7:0]             rx_data_ff;
    logic                   rx_valid_ff;
    logic                   nxt_mvs_d;
    logic [3:0]             nxt_hi_cnt;
    logic                   nxt_scs;
    logic [11:0]            nxt_tx_sr;
    logic [3:0]             nxt_tx_cnt;
    swl_pkg::swl_srx_t      nxt_rx_st;
    logic [7:0]             nxt_rx_sr;
    logic [2:0]             nxt_rx_cnt;
    logic [7:0]             nxt_rx_data;
    logic                   nxt_rx_valid;
    logic                   rise;
    logic                   fall;
    logic                   rx_bit;

    // Only the link reset touches this logic
    swl_sync u_mvs_sync (
        .clk_in   (LINK.link_clk),
        .rst_n_in (RST_N_IN),
        .ce_in    (CE_IN),
        .d_in     (LINK.master_voltage_signal),
        .q_out    (mvs_s)
    );

    assign rise   = mvs_s && !mvs_d_ff;
    assign fall   = !mvs_s && mvs_d_ff;
    assign rx_bit = hi_cnt_ff >= swl_pkg::DECODE_THR;

    // Pulse width decode and current drive
    always_comb
    begin
        nxt_mvs_d  = mvs_s;
        nxt_hi_cnt = hi_cnt_ff;
        if (rise)
            nxt_hi_cnt = 4'h1;
        else if (mvs_s && hi_cnt_ff != 4'hf)
            nxt_hi_cnt = hi_cnt_ff + 4'h1;
        nxt_scs = scs_ff;
        if (rise)
            nxt_scs = (tx_cnt_ff != 4'h0) ? tx_sr_ff[11] : swl_pkg::IDLE_BIT;
        else if (!mvs_s || hi_cnt_ff >= swl_pkg::SLV_DRIVE)
            nxt_scs = 1'h0;
    end

    // Transmit shifter, wakeup ahead of each frame
    always_comb
    begin
        TX_READY_OUT = CE_IN && tx_cnt_ff == 4'h0;
        nxt_tx_sr  = tx_sr_ff;
        nxt_tx_cnt = tx_cnt_ff;
        if (rise && tx_cnt_ff != 4'h0)
        begin
            nxt_tx_sr  = {tx_sr_ff[10:0], 1'h0};
            nxt_tx_cnt = tx_cnt_ff - 4'h1;
        end
        if (TX_READY_OUT && TX_VALID_IN)
        begin
            nxt_tx_sr  = {swl_pkg::WAKE_SEQ, swl_pkg::START_BIT, TX_DATA_IN};
            nxt_tx_cnt = swl_pkg::SLV_FRAME;
        end
    end

    // Receive framing, top bit first
    always_comb
    begin
        nxt_rx_st    = rx_st_ff;
        nxt_rx_sr    = rx_sr_ff;
        nxt_rx_cnt   = rx_cnt_ff;
        nxt_rx_data  = rx_data_ff;
        nxt_rx_valid = 1'h0;
        if (fall)
        begin
            case (rx_st_ff)
                swl_pkg::SRX_IDLE:
                begin
                    nxt_rx_cnt = 3'h0;
                    if (rx_bit)
                        nxt_rx_st = swl_pkg::SRX_DATA;
                end
                swl_pkg::SRX_DATA:
                begin
                    nxt_rx_sr  = {rx_sr_ff[6:0], rx_bit};
                    nxt_rx_cnt = rx_cnt_ff + 3'h1;
                    if (rx_cnt_ff == swl_pkg::LAST_DATA)
                    begin
                        nxt_rx_data  = {rx_sr_ff[6:0], rx_bit};
                        nxt_rx_valid = 1'h1;
                        nxt_rx_st    = swl_pkg::SRX_IDLE;
                    end
                end
                default: nxt_rx_st = swl_pkg::SRX_IDLE;
            endcase
        end
    end

    always_ff @(posedge LINK.link_clk or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            mvs_d_ff    <= 1'h0;
            hi_cnt_ff   <= 4'h0;
            scs_ff      <= 1'h0;
            tx_sr_ff    <= 12'h000;
            tx_cnt_ff   <= 4'h0;
            rx_st_ff    <= swl_pkg::SRX_IDLE;
            rx_sr_ff    <= 8'h00;
            rx_cnt_ff   <= 3'h0;
            rx_data_ff  <= 8'h00;
            rx_valid_ff <= 1'h0;
        end
        else if (CE_IN)
        begin
            mvs_d_ff    <= nxt_mvs_d;
            hi_cnt_ff   <= nxt_hi_cnt;
            scs_ff      <= nxt_scs;
            tx_sr_ff    <= nxt_tx_sr;
            tx_cnt_ff   <= nxt_tx_cnt;
            rx_st_ff    <= nxt_rx_st;
            rx_sr_ff    <= nxt_rx_sr;
            rx_cnt_ff   <= nxt_rx_cnt;
            rx_data_ff  <= nxt_rx_data;
            rx_valid_ff <= nxt_rx_valid;
        end
    end

    assign LINK.slave_current_signal = scs_ff;
    assign RX_DATA_OUT               = rx_data_ff;
    assign RX_VALID_OUT              = rx_valid_ff;
endmodule : swl_slave
`default_nettype wire

// >>> swl_master.sv
// Operation
// - Front end is sole master, card sole slave
// - Master drives two-level voltage signal
// - Slave answers by two-level current draw
// - Slave draws current only while voltage high
// - Master ignores return while its voltage low
// - Pulse width carries both clock and data
// - Bytes sent top bit first, bottom last
// - Card fills reserved bytes and bits zero
// - Other interface resets leave link running
// - Link reset frames leave other interfaces alone
// - Link runs concurrently, undisturbed by others
// - Idle zero bits sent outside frames
// - Slave sends wakeup before every frame
`timescale 1ns/1ns
`default_nettype none
module swl_master (
    // System clock, reset, enable
    input  wire logic                       CLK_SYS_IN,
    input  wire logic                       RST_N_IN,
    input  wire logic                       CE_IN,
    // Transmit byte
    input  wire logic [swl_pkg::BYTE_W-1:0] TX_DATA_IN,
    input  wire logic                       TX_VALID_IN,
    output logic                            TX_READY_OUT,
    // Receive byte
    output logic [swl_pkg::BYTE_W-1:0]      RX_DATA_OUT,
    output logic                            RX_VALID_OUT,
    // Link, this end is master
    swl_link_if.master                      LINK
);
    logic [2:0]             div_ff;
    logic [3:0]             ph_ff;
    logic                   bit_ff;
    logic                   mvs_ff;
    logic                   lclk_ff;
    logic [2:0]             nxt_div;
    logic [3:0]             nxt_ph;
    logic                   nxt_bit;
    logic                   nxt_mvs;
    logic                   nxt_lclk;
    logic [8:0]             tx_sr_ff;
    logic [3:0]             tx_cnt_ff;
    logic [8:0]             nxt_tx_sr;
    logic [3:0]             nxt_tx_cnt;
    swl_pkg::swl_mrx_t      rx_st_ff;
    logic [7:0]             rx_sr_ff;
    logic [2:0]             rx_cnt_ff;
    logic [7:0]             rx_data_ff;
    logic                   rx_valid_ff;
    swl_pkg::swl_mrx_t      nxt_rx_st;
    logic [7:0]             nxt_rx_sr;
    logic [2:0]             nxt_rx_cnt;
    logic [7:0]             nxt_rx_data;
    logic                   nxt_rx_valid;
    logic                   scs_s;
    logic                   tick;
    logic                   bit_end;
    logic                   sample;

    // Return current comes from the card, so it is synchronised first
    swl_sync u_scs_sync (
        .clk_in   (CLK_SYS_IN),
        .rst_n_in (RST_N_IN),
        .ce_in    (CE_IN),
        .d_in     (LINK.slave_current_signal),
        .q_out    (scs_s)
    );

    assign tick    = div_ff == swl_pkg::DIV_LAST;
    assign bit_end = tick && ph_ff == swl_pkg::BIT_LAST;
    // One sample per bit, late in the shortest high phase
    assign sample  = tick && ph_ff == swl_pkg::SAMPLE_TICK && mvs_ff;

    // Link clock divider and pulse width bit cell
    always_comb
    begin
        nxt_div = tick ? 3'h0 : div_ff + 3'h1;
        nxt_ph  = ph_ff;
        nxt_bit = bit_ff;
        if (tick)
            nxt_ph = bit_end ? 4'h0 : ph_ff + 4'h1;
        if (bit_end)
            nxt_bit = (tx_cnt_ff != 4'h0) ? tx_sr_ff[8] : swl_pkg::IDLE_BIT;
        // Long high for one, short high for zero
        nxt_mvs  = nxt_ph < (nxt_bit ? swl_pkg::HIGH_ONE : swl_pkg::HIGH_ZERO);
        nxt_lclk = nxt_div < swl_pkg::DIV_HALF;
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            div_ff  <= 3'h0;
            ph_ff   <= swl_pkg::BIT_LAST;
            bit_ff  <= 1'h0;
            mvs_ff  <= 1'h0;
            // Rests high as at divider count zero, so no short pulse follows release
            lclk_ff <= 1'h1;
        end
        else if (CE_IN)
        begin
            div_ff  <= nxt_div;
            ph_ff   <= nxt_ph;
            bit_ff  <= nxt_bit;
            mvs_ff  <= nxt_mvs;
            lclk_ff <= nxt_lclk;
        end
    end

    // Transmit shifter: start bit, then byte top bit first
    always_comb
    begin
        TX_READY_OUT = CE_IN && tx_cnt_ff == 4'h0;
        nxt_tx_sr    = tx_sr_ff;
        nxt_tx_cnt   = tx_cnt_ff;
        if (bit_end && tx_cnt_ff != 4'h0)
        begin
            nxt_tx_sr  = {tx_sr_ff[7:0], 1'h0};
            nxt_tx_cnt = tx_cnt_ff - 4'h1;
        end
        if (TX_READY_OUT && TX_VALID_IN)
        begin
            nxt_tx_sr  = {swl_pkg::START_BIT, TX_DATA_IN};
            nxt_tx_cnt = swl_pkg::MST_FRAME;
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            tx_sr_ff  <= 9'h000;
            tx_cnt_ff <= 4'h0;
        end
        else if (CE_IN)
        begin
            tx_sr_ff  <= nxt_tx_sr;
            tx_cnt_ff <= nxt_tx_cnt;
        end
    end

    // Receive: wakeup pulse, optional zeros, start bit, eight data bits
    always_comb
    begin
        nxt_rx_st    = rx_st_ff;
        nxt_rx_sr    = rx_sr_ff;
        nxt_rx_cnt   = rx_cnt_ff;
        nxt_rx_data  = rx_data_ff;
        nxt_rx_valid = 1'h0;
        if (sample)
        begin
            case (rx_st_ff)
                swl_pkg::RX_IDLE:
                begin
                    if (scs_s)
                        nxt_rx_st = swl_pkg::RX_WOKE;
                end
                swl_pkg::RX_WOKE:
                begin
                    nxt_rx_cnt = 3'h0;
                    if (scs_s)
                        nxt_rx_st = swl_pkg::RX_DATA;
                end
                swl_pkg::RX_DATA:
                begin
                    nxt_rx_sr  = {rx_sr_ff[6:0], scs_s};
                    nxt_rx_cnt = rx_cnt_ff + 3'h1;
                    if (rx_cnt_ff == swl_pkg::LAST_DATA)
                    begin
                        nxt_rx_data  = {rx_sr_ff[6:0], scs_s};
                        nxt_rx_valid = 1'h1;
                        nxt_rx_st    = swl_pkg::RX_IDLE;
                    end
                end
                default: nxt_rx_st = swl_pkg::RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            rx_st_ff    <= swl_pkg::RX_IDLE;
            rx_sr_ff    <= 8'h00;
            rx_cnt_ff   <= 3'h0;
            rx_data_ff  <= 8'h00;
            rx_valid_ff <= 1'h0;
        end
        else if (CE_IN)
        begin
            rx_st_ff    <= nxt_rx_st;
            rx_sr_ff    <= nxt_rx_sr;
            rx_cnt_ff   <= nxt_rx_cnt;
            rx_data_ff  <= nxt_rx_data;
            rx_valid_ff <= nxt_rx_valid;
        end
    end

    // Link pins carry no dependence on any other card interface
    assign LINK.master_voltage_signal = mvs_ff;
    assign LINK.link_clk              = lclk_ff;
    assign RX_DATA_OUT                = rx_data_ff;
    assign RX_VALID_OUT               = rx_valid_ff;
endmodule : swl_master
`default_nettype wire

// >>> swl_link_props.sv
`timescale 1ns/1ns
`default_nettype none
module swl_link_props (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    // Link wire
    input wire logic link_clk,
    input wire logic master_voltage_signal,
    input wire logic slave_current_signal
);
    logic [7:0] hi_ff;
    logic [7:0] nxt_hi;
    logic [7:0] cur_ff;
    logic [7:0] nxt_cur;

    default clocking @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!RST_N_IN);

    // Cycles the voltage and the current have stayed high
    always_comb
    begin
        nxt_hi  = master_voltage_signal ? hi_ff + 8'h01 : 8'h00;
        nxt_cur = slave_current_signal ? cur_ff + 8'h01 : 8'h00;
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            hi_ff  <= 8'h00;
            cur_ff <= 8'h00;
        end
        else
        begin
            hi_ff  <= nxt_hi;
            cur_ff <= nxt_cur;
        end
    end

    chk_curr_in_high: assert property (
        slave_current_signal |-> master_voltage_signal)
        else $error("current drawn while voltage low");
    chk_pulse_width: assert property (
        $fell(master_voltage_signal) |-> (hi_ff == 8'h40 || hi_ff == 8'h60))
        else $error("high phase neither 8 nor 12 ticks");
    chk_cell_period: assert property (
        $rose(master_voltage_signal) |-> ##128 $rose(master_voltage_signal))
        else $error("bit cell not 16 ticks");
    chk_rise_on_clk: assert property (
        $rose(master_voltage_signal) |-> $rose(link_clk))
        else $error("voltage rise off the link clock rise");
    chk_clk_shape: assert property (
        $rose(link_clk) |-> link_clk[*4] ##1 !link_clk[*4] ##1 link_clk)
        else $error("link clock not 4 high 4 low");
    chk_curr_start: assert property (
        $rose(slave_current_signal) |-> (hi_ff >= 8'h10 && hi_ff <= 8'h18))
        else $error("current start outside 2 to 3 ticks");
    chk_curr_length: assert property (
        $fell(slave_current_signal) |-> cur_ff == 8'h20)
        else $error("current pulse not 4 ticks");
    chk_reset_quiet: assert property (
        $rose(RST_N_IN) |-> (!master_voltage_signal && !slave_current_signal)[*3])
        else $error("line active right after reset");
endmodule : swl_link_props
`default_nettype wire

// >>> single_wire_link_signalling_tb.sv
`timescale 1ns/1ns
`default_nettype none
module single_wire_link_signalling_tb;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        ce = 1'b1;
    logic [7:0]  m_txd = 8'h00;
    logic        m_txv = 1'b0;
    logic [7:0]  s_txd = 8'h00;
    logic        s_txv = 1'b0;
    logic        m_rdy, s_rdy, m_rxv, s_rxv, l_rxv, l_prev, seen;
    logic [7:0]  m_rxd, s_rxd, l_rxd;
    logic [7:0]  tab [4] = '{8'h00, 8'hff, 8'h80, 8'h01};
    logic [11:0] q_srx[$], q_mrx[$], q_wv[$], q_wc[$], q_lrx[$], sh_v, sh_c;
    logic        q_rg[$];
    logic [31:0] seed = 32'h50d64b2a;
    int          failures = 0, n_compared = 0, n_v = 0, n_c = 0, hcnt = 0;

    swl_link_if lnk ();
    swl_link_if lone ();
    wire logic   lclk = lnk.link_clk;
    wire logic   mvs = lnk.master_voltage_signal;
    wire logic   lmvs = lone.master_voltage_signal;

    always #(swl_pkg::SYS_CLK_NS / 2) clk_sys = ~clk_sys;

    swl_master swl_master_inst (.CLK_SYS_IN(clk_sys), .RST_N_IN(rst_n), .CE_IN(ce),
        .TX_DATA_IN(m_txd), .TX_VALID_IN(m_txv), .TX_READY_OUT(m_rdy),
        .RX_DATA_OUT(m_rxd), .RX_VALID_OUT(m_rxv), .LINK(lnk));
    swl_slave swl_slave_inst (.RST_N_IN(rst_n), .CE_IN(ce), .TX_DATA_IN(s_txd),
        .TX_VALID_IN(s_txv), .TX_READY_OUT(s_rdy), .RX_DATA_OUT(s_rxd),
        .RX_VALID_OUT(s_rxv), .LINK(lnk));
    // Second master faces a return that is noise while its voltage is low
    swl_master swl_master_lone_inst (.CLK_SYS_IN(clk_sys), .RST_N_IN(rst_n), .CE_IN(ce),
        .TX_DATA_IN(8'h00), .TX_VALID_IN(1'b0), .TX_READY_OUT(),
        .RX_DATA_OUT(l_rxd), .RX_VALID_OUT(l_rxv), .LINK(lone));
    swl_link_props swl_link_props_inst (.CLK_SYS_IN(clk_sys), .RST_N_IN(rst_n),
        .link_clk(lclk), .master_voltage_signal(mvs),
        .slave_current_signal(lnk.slave_current_signal));

    function automatic logic [7:0] pick(input int i);
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h00000000);
        pick = (i < 4) ? tab[i] : seed[7:0];
    endfunction : pick

    task automatic check_q(input logic [11:0] got, ref logic [11:0] q[$], input string what);
        bit          empty;
        logic [11:0] exp;
        begin
            n_compared++;
            empty = (q.size() == 0);
            exp = empty ? 12'h000 : q.pop_front();
            if (empty || got !== exp)
            begin
                failures++;
                $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
            end
        end
    endtask : check_q

    // Idle zeros are skipped; a one opens a frame of len cells
    task automatic parse(input logic b, ref int n, ref logic [11:0] sh, input int len,
                         ref logic [11:0] q[$], input string what);
        begin
            if (n != 0 || b)
            begin
                sh = (n == 0) ? 12'h000 : sh;
                sh = {sh[10:0], b};
                n++;
                if (n == len)
                begin
                    check_q(sh, q, what);
                    n = 0;
                end
            end
        end
    endtask : parse

    task automatic m_send(input logic [7:0] d);
        int n;
        begin
            n = 0;
            @(negedge clk_sys);
            while (m_rdy !== 1'b1 && n < 3000)
            begin
                @(negedge clk_sys);
                n++;
            end
            if (n == 3000)
            begin
                failures++;
                $display("BAD %0t master never ready", $time);
            end
            @(posedge clk_sys);
            m_txd <= d;
            m_txv <= 1'b1;
            q_srx.push_back({4'h0, d});
            q_wv.push_back({3'h0, swl_pkg::START_BIT, d});
            @(posedge clk_sys);
            m_txv <= 1'b0;
        end
    endtask : m_send

    task automatic s_send(input logic [7:0] d);
        int n;
        begin
            n = 0;
            @(negedge lclk);
            while (s_rdy !== 1'b1 && n < 400)
            begin
                @(negedge lclk);
                n++;
            end
            if (n == 400)
            begin
                failures++;
                $display("BAD %0t slave never ready", $time);
            end
            @(posedge lclk);
            s_txd <= d;
            s_txv <= 1'b1;
            q_mrx.push_back({4'h0, d});
            q_wc.push_back({swl_pkg::WAKE_SEQ, swl_pkg::START_BIT, d});
            @(posedge lclk);
            s_txv <= 1'b0;
        end
    endtask : s_send

    task automatic rogue_send(input logic [7:0] d);
        logic [11:0] f;
        begin
            f = {swl_pkg::WAKE_SEQ, swl_pkg::START_BIT, d};
            for (int i = 11; i >= 0; i--)
                q_rg.push_back(f[i]);
            q_lrx.push_back({4'h0, d});
        end
    endtask : rogue_send

    task automatic check_drained;
        begin
            n_compared++;
            if (q_srx.size() + q_mrx.size() + q_wv.size() + q_wc.size() + q_lrx.size() != 0)
            begin
                failures++;
                $display("BAD %0t frames left undelivered", $time);
            end
        end
    endtask : check_drained

    task automatic final_report;
        begin
            $display("compared %0d failures %0d", n_compared, failures);
            if (failures == 0 && n_compared > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask : final_report

    always @(negedge clk_sys)
    begin
        if (m_rxv === 1'b1)
            check_q({4'h0, m_rxd}, q_mrx, "master rx");
        if (l_rxv === 1'b1)
            check_q({4'h0, l_rxd}, q_lrx, "lone rx");
    end

    always @(negedge lclk)
        if (s_rxv === 1'b1)
            check_q({4'h0, s_rxd}, q_srx, "slave rx");

    // Cell value on the wire: long high phase is a one, current seen while high is a one
    always @(negedge clk_sys)
    begin
        if (!rst_n)
        begin
            n_v = 0;
            n_c = 0;
            hcnt = 0;
            seen = 1'b0;
        end
        else if (mvs === 1'b1)
        begin
            hcnt++;
            seen = seen | (lnk.slave_current_signal === 1'b1);
        end
        else if (hcnt != 0)
        begin
            parse(hcnt >= 80, n_v, sh_v, 9, q_wv, "wire voltage");
            parse(seen, n_c, sh_c, 12, q_wc, "wire current");
            hcnt = 0;
            seen = 1'b0;
        end
    end

    always @(posedge clk_sys)
    begin
        l_prev <= lmvs;
        if (lmvs !== 1'b1)
            lone.slave_current_signal <= ~lone.slave_current_signal;
        else
            lone.slave_current_signal <= (q_rg.size() > 0) ? q_rg[0] : 1'b0;
        if (l_prev === 1'b1 && lmvs !== 1'b1 && q_rg.size() > 0)
            void'(q_rg.pop_front());
    end

    initial
    begin
        lone.slave_current_signal = 1'b0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        rogue_send(8'ha5);
        rogue_send(8'h3c);
        fork
            for (int i = 0; i < 8; i++)
                m_send(pick(i));
            for (int i = 0; i < 8; i++)
                s_send(pick(i));
        join
        repeat (3000) @(posedge clk_sys);
        check_drained();
        m_send(8'h5a);
        s_send(8'hc3);
        repeat (600) @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        q_srx.delete();
        q_mrx.delete();
        q_wv.delete();
        q_wc.delete();
        rst_n <= 1'b1;
        fork
            m_send(8'h96);
            s_send(8'h69);
        join
        repeat (3000) @(posedge clk_sys);
        check_drained();
        final_report();
    end

    initial
    begin
        repeat (60000) @(posedge clk_sys);
        failures++;
        $display("BAD %0t watchdog expired", $time);
        final_report();
    end
endmodule : single_wire_link_signalling_tb
`default_nettype wire
